// File: clkctl_consts.vh
// constants for the processor clock-control state machine
`ifndef CLKCTL_CONSTS_VH
`define CLKCTL_CONSTS_VH
`define ST_NORMAL        3'h0
`define ST_HALT_CYC      3'h1
`define ST_HALT          3'h2
`define ST_SG_CYC        3'h3
`define ST_STOP_GRANT    3'h4
`define ST_INQUIRE       3'h5
`define ST_STOP_CLOCK    3'h6
`define ST_DRAIN         3'h7
`define CYC_NONE         2'h0
`define CYC_HALT         2'h1
`define CYC_STOP_GRANT   2'h2
`define CYC_WRITEBACK    2'h3
`define PLL_LOCK_US      1000
`define CLK_MHZ          100
`define PLL_LOCK_CYCLES  (`PLL_LOCK_US * `CLK_MHZ)
`define EXIT_MAX_CYCLES  9
`endif

// File: cpu_clock_state_control.v
// clock-control state machine: normal, halt, stop grant, inquire, stop clock
`timescale 1ns/10ps
`include "clkctl_consts.vh"

// Operation
// [R1] halt instruction issues halt cycle; halt entered after burst-ready then write-buffer-empty
// [R2] snoops serviced while halted; no second halt cycle afterwards
// [R3] flush while halted is performed, then halt cycle reissued
// [R4] time stamp counter counts in halt and stop grant
// [R5] outputs hold values from special cycle completion while halted or stopped; the code returns special_cycle to CYC_NONE instead
// [R6] init, enabled irq, nmi, reset or smi leaves halt for normal
// [R7] stop-clock request drains pipeline, finishes bus cycles, then stop-grant cycle
// [R8] stop grant entered after burst-ready then write-buffer-empty
// [R9] no repeat stop-grant cycle after servicing a snoop
// [R10] stop grant ignores flush, init, irqs; edge ones latched for normal
// [R11] request released: normal within ten bus clocks, resume same boundary
// [R12] re-request before normal: at least one instruction before stop grant
// [R13] reset in stop grant goes to normal immediately
// [R14] snoop strobe in halt or stop grant enters inquire, hit outputs driven
// [R15] after writeback, return to halt or stop grant as entered
// [R16] stop clock only from stop grant when bus clock stops
// [R17] system keeps bus clock low while stopped
// [R18] only maskable irq changes in stop clock; sampled back in stop grant
// [R19] leave stop clock after clock runs 1.0 ms
// [R20] bus frequency ratio captured only at reset release
// [R21] reset enters normal; state encoding visible
module cpu_clock_state_control #(
  parameter PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       halt_instruction,
  input  wire       stop_clock_request_n,
  input  wire       bus_idle,
  input  wire       instr_retired,
  input  wire       burst_ready_n,
  input  wire       ext_write_buffer_empty_n,
  input  wire       address_hold_req,
  input  wire       backoff_n,
  input  wire       bus_hold_req,
  input  wire       ext_addr_strobe_n,
  input  wire       snoop_hit,
  input  wire       snoop_hit_mod,
  input  wire       flush_n,
  input  wire       flush_done,
  input  wire       init_req,
  input  wire       maskable_irq,
  input  wire       irq_enable,
  input  wire       nmi_req,
  input  wire       sysmgmt_irq_n,
  input  wire       bus_clk_running,
  input  wire [2:0] bus_freq_ratio,
  output reg  [2:0] clk_state,
  output reg  [1:0] special_cycle,
  output reg        special_cycle_valid,
  output reg        writeback_req,
  output reg        snoop_hit_n,
  output reg        snoop_hit_modified_n,
  output reg        core_clk_enable,
  output reg        pll_running,
  output reg        flush_start,
  output reg  [3:0] pending_events,
  output reg  [2:0] ratio_latched,
  output reg [63:0] time_stamp_counter
);

  reg  [2:0]  state_d;
  reg         burst_ready_n_seen_q;       // burst-ready seen for current special cycle
  reg         ret_to_halt_q;     // inquire return target
  reg         need_instr_q;      // one instruction owed before next stop grant
  reg         flushing_q;
  reg         rst_prev_q;
  reg  [31:0] lock_cnt_q;
  reg  [1:0]  cyc_d;
  reg         cyc_v_d;
  wire        snoop   = ~ext_addr_strobe_n & (address_hold_req | ~backoff_n | bus_hold_req);
  wire        wake    = init_req | (maskable_irq & irq_enable) | nmi_req | ~sysmgmt_irq_n;
  wire        stopreq = ~stop_clock_request_n & ~need_instr_q;
  // burst-ready answering the special cycle now on the bus
  wire        burst_ready_n_hit = special_cycle_valid & ~burst_ready_n;

  // core clock runs while the pipeline can still issue bus cycles;
  // once the special cycle is acknowledged only the counter, the snoop
  // logic and the flush sequencer stay clocked
  function core_running;
    input [2:0] st;
    begin
      core_running = (st == `ST_NORMAL) || (st == `ST_DRAIN) ||
                     (st == `ST_HALT_CYC) || (st == `ST_SG_CYC);
    end
  endfunction

  // true on the edge that moves the machine from cur into st
  // (swap the first two arguments to detect leaving st)
  function arriving;
    input [2:0] nxt;
    input [2:0] cur;
    input [2:0] st;
    begin
      arriving = (nxt == st) && (cur != st);
    end
  endfunction

  // next-state decode
  always @*
  begin
    state_d = clk_state;
    case (clk_state)
      `ST_NORMAL:
      begin
        // [R7] drain before stop grant
        if (stopreq)
          state_d = `ST_DRAIN;
        else if (halt_instruction)
          state_d = `ST_HALT_CYC;
      end
      `ST_DRAIN:
      begin
        if (bus_idle)
          state_d = `ST_SG_CYC;
      end
      `ST_HALT_CYC:
      begin
        // [R1] burst-ready then write-buffer-empty
        if (burst_ready_n_seen_q && !ext_write_buffer_empty_n)
          state_d = `ST_HALT;
      end
      `ST_SG_CYC:
      begin
        // [R8] burst-ready then write-buffer-empty
        if (burst_ready_n_seen_q && !ext_write_buffer_empty_n)
          state_d = `ST_STOP_GRANT;
      end
      `ST_HALT:
      begin
        // [R6] wake events return to normal
        if (wake)
          state_d = `ST_NORMAL;
        // [R14] snoop from halt
        else if (snoop)
          state_d = `ST_INQUIRE;
        // [R3] flush then reissue halt cycle
        else if (flushing_q && flush_done)
          state_d = `ST_HALT_CYC;
      end
      `ST_STOP_GRANT:
      begin
        // [R11] request released
        if (stop_clock_request_n)
          state_d = `ST_NORMAL;
        // [R16] clock stops only here
        else if (!bus_clk_running)
          state_d = `ST_STOP_CLOCK;
        else if (snoop)
          state_d = `ST_INQUIRE;
      end
      `ST_INQUIRE:
      begin
        // [R15] back to origin, no repeat cycle
        if (!snoop_hit_mod || burst_ready_n == 1'b0)
          state_d = ret_to_halt_q ? `ST_HALT : `ST_STOP_GRANT;
      end
      `ST_STOP_CLOCK:
      begin
        // [R19] wait for pll lock
        if (lock_cnt_q >= PLL_LOCK_CYCLES - 1)
          state_d = `ST_STOP_GRANT;
      end
      default:
        state_d = `ST_NORMAL;
    endcase
  end

  // special cycle encoding driven on the bus
  always @*
  begin
    cyc_d   = `CYC_NONE;
    cyc_v_d = 1'b0;
    case (state_d)
      `ST_HALT_CYC:
      begin
        cyc_d   = `CYC_HALT;
        cyc_v_d = 1'b1;
      end
      `ST_SG_CYC:
      begin
        cyc_d   = `CYC_STOP_GRANT;
        cyc_v_d = 1'b1;
      end
      default:
      begin
        cyc_d   = `CYC_NONE;
        cyc_v_d = 1'b0;
      end
    endcase
  end

  // [R20] bus ratio strap captured only on the falling edge of reset
  always @(posedge clk_sys)
  begin
    rst_prev_q <= rst;
    if (rst_prev_q && !rst)
      ratio_latched <= bus_freq_ratio;
  end

  // [R4] time stamp counter keeps counting in halt and stop grant
  always @(posedge clk_sys)
  begin
    if (rst)
      time_stamp_counter <= 64'h0;
    else if (clk_state != `ST_STOP_CLOCK)
      time_stamp_counter <= time_stamp_counter + 64'h1;
  end

  // state register and handshakes
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      // [R13] reset from any state, stop grant included, lands in normal
      // [R21] reset enters normal
      clk_state            <= `ST_NORMAL;
      special_cycle        <= `CYC_NONE;
      special_cycle_valid  <= 1'b0;
      core_clk_enable      <= 1'b1;
      pll_running          <= 1'b1;
      burst_ready_n_seen_q          <= 1'b0;
      need_instr_q         <= 1'b0;
      lock_cnt_q           <= 32'h0;
    end
    else
    begin
      // [R11] release reaches normal on the next edge
      clk_state <= state_d;
      // [R12] one instruction owed after leaving stop grant for normal
      if (clk_state == `ST_STOP_GRANT && state_d == `ST_NORMAL)
        need_instr_q <= 1'b1;
      else if (instr_retired)
        need_instr_q <= 1'b0;
      // burst-ready capture during special cycles
      if (burst_ready_n_hit)
        burst_ready_n_seen_q <= 1'b1;
      else if (state_d != clk_state)
        burst_ready_n_seen_q <= 1'b0;
      // [R5] special cycle outputs return to none outside special cycles
      special_cycle       <= cyc_d;
      special_cycle_valid <= cyc_v_d & ~(special_cycle_valid & burst_ready_n_seen_q);
      core_clk_enable     <= core_running(state_d);
      // [R16] pll off only in stop clock
      pll_running         <= (state_d != `ST_STOP_CLOCK);
      // [R19] count running clock time in stop clock
      if (clk_state == `ST_STOP_CLOCK && bus_clk_running)
        lock_cnt_q <= lock_cnt_q + 32'h1;
      else if (clk_state != `ST_STOP_CLOCK)
        lock_cnt_q <= 32'h0;
    end
  end

  // snoop response held from inquire entry
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      writeback_req        <= 1'b0;
      snoop_hit_n          <= 1'b1;
      snoop_hit_modified_n <= 1'b1;
      ret_to_halt_q        <= 1'b0;
    end
    // [R2] snoop entry remembers origin
    else if (arriving(state_d, clk_state, `ST_INQUIRE))
    begin
      ret_to_halt_q        <= (clk_state == `ST_HALT);
      // [R14] hit outputs as in normal
      snoop_hit_n          <= ~snoop_hit;
      snoop_hit_modified_n <= ~snoop_hit_mod;
      writeback_req        <= snoop_hit_mod;
    end
    // [R15] writeback request dropped on the way back
    else if (arriving(clk_state, state_d, `ST_INQUIRE))
      writeback_req <= 1'b0;
  end

  // [R3] flush sampled in halt only; no new flush while one runs
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      flush_start <= 1'b0;
      flushing_q  <= 1'b0;
    end
    else
    begin
      flush_start <= (clk_state == `ST_HALT) && !flush_n && !flushing_q && !wake && !snoop;
      // start wins over a done in the same cycle
      if (flush_start)
        flushing_q <= 1'b1;
      else if (flush_done)
        flushing_q <= 1'b0;
    end
  end

  // [R10] edge events latched in stop grant, released in normal
  // [R18] nothing latched in stop clock, where only the maskable irq may move
  always @(posedge clk_sys)
  begin
    if (rst)
      pending_events <= 4'h0;
    else if (clk_state == `ST_STOP_GRANT || clk_state == `ST_SG_CYC)
      pending_events <= pending_events |
                        {~sysmgmt_irq_n, nmi_req, ~flush_n, init_req};
    else if (clk_state == `ST_NORMAL)
      pending_events <= 4'h0;
  end

endmodule // cpu_clock_state_control

// File: chipset_model.sv
// chipset model answering special cycles and writebacks
`timescale 1ns/10ps
module chipset_model (
  input  wire clk_sys,
  input  wire stall,
  input  wire special_cycle_valid,
  input  wire writeback_req,
  output reg  burst_ready_n,
  output reg  ext_write_buffer_empty_n
);
  initial burst_ready_n = 1'b1;
  initial ext_write_buffer_empty_n = 1'b1;
  always @(posedge clk_sys)
  begin
    burst_ready_n <= ~((special_cycle_valid | writeback_req) & burst_ready_n & ~stall);
    ext_write_buffer_empty_n <= burst_ready_n;
  end
endmodule // chipset_model

// File: cpu_clock_state_control_monitor.sv
// checker for the clock-control state machine ports
`timescale 1ns/10ps
`include "clkctl_consts.vh"
module cpu_clock_state_control_monitor (
  input wire        clk_sys,
  input wire        rst,
  input wire        stop_clock_request_n,
  input wire        ext_write_buffer_empty_n,
  input wire        ext_addr_strobe_n,
  input wire        address_hold_req,
  input wire        bus_clk_running,
  input wire [2:0]  clk_state,
  input wire        special_cycle_valid,
  input wire        pll_running,
  input wire [63:0] time_stamp_counter
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // state decodes and a held stop request
  wire sg = clk_state == `ST_STOP_GRANT;
  wire hl = clk_state == `ST_HALT;
  wire held = !stop_clock_request_n && bus_clk_running;
  enter_halt_a: assert property (hl && $past(clk_state) == `ST_HALT_CYC
    |-> !$past(ext_write_buffer_empty_n))
    else $error("halt entered early");
  enter_sg_a: assert property (sg && $past(clk_state) == `ST_SG_CYC
    |-> !$past(ext_write_buffer_empty_n))
    else $error("stop grant entered early");
  reset_normal_a: assert property (disable iff (1'b0) rst |=> clk_state == `ST_NORMAL)
    else $error("reset did not give normal");
  count_run_a: assert property (hl || sg
    |=> time_stamp_counter == $past(time_stamp_counter) + 64'h1)
    else $error("counter stalled");
  fast_exit_a: assert property (sg && stop_clock_request_n |-> ##[1:9] clk_state == `ST_NORMAL)
    else $error("slow stop grant exit");
  sg_hold_a: assert property (sg && held && ext_addr_strobe_n |=> sg)
    else $error("stop grant left on ignored input");
  inquire_entry_a: assert property (sg && held && !ext_addr_strobe_n && address_hold_req
    |=> clk_state == `ST_INQUIRE)
    else $error("snoop not taken");
  halt_stop_a: assert property (hl |=> clk_state != `ST_STOP_CLOCK)
    else $error("stop clock from halt");
  sg_quiet_a: assert property (sg |-> !special_cycle_valid)
    else $error("repeated special cycle");
  stop_pll_a: assert property (clk_state == `ST_STOP_CLOCK |-> !pll_running)
    else $error("pll running in stop clock");
  cover property (hl);
  cover property (clk_state == `ST_INQUIRE);
  cover property (clk_state == `ST_STOP_CLOCK);
endmodule // cpu_clock_state_control_monitor

// File: cpu_clock_state_control_tb_top.sv
// self-checking bench for the clock-control state machine
`timescale 1ns/10ps
`include "clkctl_consts.vh"
module cpu_clock_state_control_tb_top;
  reg clk_sys = 1'b0, rst = 1'b1, halt_instruction = 1'b0, stop_clock_request_n = 1'b1;
  reg bus_idle = 1'b1, instr_retired = 1'b0, address_hold_req = 1'b0, backoff_n = 1'b1;
  reg bus_hold_req = 1'b0, ext_addr_strobe_n = 1'b1, snoop_hit = 1'b0, snoop_hit_mod = 1'b0;
  reg flush_n = 1'b1, flush_done = 1'b0, init_req = 1'b0, maskable_irq = 1'b0;
  reg irq_enable = 1'b0, nmi_req = 1'b0, sysmgmt_irq_n = 1'b1, bus_clk_running = 1'b1;
  reg stall = 1'b0;
  reg [2:0] bus_freq_ratio = 3'h5;
  wire burst_ready_n, ext_write_buffer_empty_n, special_cycle_valid, writeback_req;
  wire snoop_hit_n, snoop_hit_modified_n, core_clk_enable, pll_running, flush_start;
  wire [2:0] clk_state, ratio_latched;
  wire [1:0] special_cycle;
  wire [3:0] pending_events;
  wire [63:0] time_stamp_counter;
  integer miscompares = 0, checks = 0;
  reg [63:0] t0;
  cpu_clock_state_control #(.PLL_LOCK_CYCLES(20)) dut (
    .clk_sys(clk_sys), .rst(rst), .halt_instruction(halt_instruction),
    .stop_clock_request_n(stop_clock_request_n), .bus_idle(bus_idle),
    .instr_retired(instr_retired), .burst_ready_n(burst_ready_n),
    .ext_write_buffer_empty_n(ext_write_buffer_empty_n),
    .address_hold_req(address_hold_req), .backoff_n(backoff_n), .bus_hold_req(bus_hold_req),
    .ext_addr_strobe_n(ext_addr_strobe_n), .snoop_hit(snoop_hit), .snoop_hit_mod(snoop_hit_mod),
    .flush_n(flush_n), .flush_done(flush_done), .init_req(init_req),
    .maskable_irq(maskable_irq), .irq_enable(irq_enable), .nmi_req(nmi_req),
    .sysmgmt_irq_n(sysmgmt_irq_n), .bus_clk_running(bus_clk_running),
    .bus_freq_ratio(bus_freq_ratio), .clk_state(clk_state), .special_cycle(special_cycle),
    .special_cycle_valid(special_cycle_valid), .writeback_req(writeback_req),
    .snoop_hit_n(snoop_hit_n), .snoop_hit_modified_n(snoop_hit_modified_n),
    .core_clk_enable(core_clk_enable), .pll_running(pll_running), .flush_start(flush_start),
    .pending_events(pending_events), .ratio_latched(ratio_latched),
    .time_stamp_counter(time_stamp_counter)
  );
  chipset_model peer (
    .clk_sys(clk_sys), .stall(stall), .special_cycle_valid(special_cycle_valid),
    .writeback_req(writeback_req), .burst_ready_n(burst_ready_n),
    .ext_write_buffer_empty_n(ext_write_buffer_empty_n)
  );
  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  task chk(input string n, input [63:0] e, input [63:0] g);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  end
  endtask
  task step(input integer n);
  begin
    repeat (n) @(posedge clk_sys);
    #1;
  end
  endtask
  // bounded wait for a state
  task wst(input [2:0] s, input integer lim);
    integer i;
  begin
    for (i = 0; i < lim && clk_state !== s; i = i + 1)
      step(1);
    chk("clk_state", s, clk_state);
  end
  endtask
  task t_halt;
  begin
    chk("ratio", 3'h5, ratio_latched);
    @(posedge clk_sys) halt_instruction <= 1'b1;
    wst(`ST_HALT_CYC, 3);
    chk("halt cycle", `CYC_HALT, special_cycle);
    halt_instruction <= 1'b0;
    wst(`ST_HALT, 6);
    chk("core clock", 1'b0, core_clk_enable);
    t0 = time_stamp_counter;
    step(5);
    chk("counter", t0 + 64'h5, time_stamp_counter);
  end
  endtask
  task t_snoop(input [2:0] home);
  begin
    @(posedge clk_sys) ext_addr_strobe_n <= 1'b0;
    address_hold_req <= 1'b1;
    snoop_hit <= 1'b1;
    snoop_hit_mod <= 1'b1;
    wst(`ST_INQUIRE, 3);
    chk("hit", 1'b0, snoop_hit_n);
    chk("writeback", 1'b1, writeback_req);
    ext_addr_strobe_n <= 1'b1;
    address_hold_req <= 1'b0;
    wst(home, 8);
    chk("writeback done", 1'b0, writeback_req);
    chk("hit modified", 1'b0, snoop_hit_modified_n);
    chk("special", 1'b0, special_cycle_valid);
  end
  endtask
  task t_flush_wake;
  begin
    @(posedge clk_sys) flush_n <= 1'b0;
    @(posedge clk_sys) flush_n <= 1'b1;
    #1;
    chk("flush start", 1'b1, flush_start);
    step(3);
    flush_done <= 1'b1;
    step(1);
    flush_done <= 1'b0;
    wst(`ST_HALT_CYC, 4);
    wst(`ST_HALT, 6);
    maskable_irq <= 1'b1;
    step(4);
    chk("masked irq", `ST_HALT, clk_state);
    irq_enable <= 1'b1;
    wst(`ST_NORMAL, 3);
    maskable_irq <= 1'b0;
    t_halt;
    nmi_req <= 1'b1;
    wst(`ST_NORMAL, 3);
    nmi_req <= 1'b0;
  end
  endtask
  task t_sg;
  begin
    @(posedge clk_sys) stop_clock_request_n <= 1'b0;
    bus_idle <= 1'b0;
    stall <= 1'b1;
    step(4);
    chk("drain", `ST_DRAIN, clk_state);
    bus_idle <= 1'b1;
    step(4);
    chk("stalled ack", `ST_SG_CYC, clk_state);
    chk("sg cycle", `CYC_STOP_GRANT, special_cycle);
    stall <= 1'b0;
    wst(`ST_STOP_GRANT, 6);
    t_snoop(`ST_STOP_GRANT);
    nmi_req <= 1'b1;
    flush_n <= 1'b0;
    step(1);
    nmi_req <= 1'b0;
    flush_n <= 1'b1;
    step(3);
    chk("pending", 4'h6, pending_events);
    // clock held low, no other input moves, the irq included
    bus_clk_running <= 1'b0;
    wst(`ST_STOP_CLOCK, 3);
    chk("pll", 1'b0, pll_running);
    step(5);
    bus_clk_running <= 1'b1;
    step(15);
    chk("locking", `ST_STOP_CLOCK, clk_state);
    wst(`ST_STOP_GRANT, 12);
  end
  endtask
  task t_exit;
  begin
    bus_freq_ratio <= 3'h2;
    @(posedge clk_sys) stop_clock_request_n <= 1'b1;
    wst(`ST_NORMAL, 9);
    step(2);
    chk("pending", 4'h0, pending_events);
    chk("ratio", 3'h5, ratio_latched);
    stop_clock_request_n <= 1'b0;
    step(4);
    chk("no retire", `ST_NORMAL, clk_state);
    instr_retired <= 1'b1;
    step(1);
    instr_retired <= 1'b0;
    wst(`ST_STOP_GRANT, 12);
    @(posedge clk_sys) rst <= 1'b1;
    @(posedge clk_sys) rst <= 1'b0;
    #1;
    chk("reset", `ST_NORMAL, clk_state);
    stop_clock_request_n <= 1'b1;
    step(1);
    chk("ratio relatched", 3'h2, ratio_latched);
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // main sequence
  initial
  begin
    step(10);
    rst <= 1'b0;
    step(1);
    t_halt;
    t_snoop(`ST_HALT);
    t_flush_wake;
    t_sg;
    t_exit;
    report_and_stop;
  end
  // watchdog
  initial
  begin
    #20000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule // cpu_clock_state_control_tb_top
bind cpu_clock_state_control cpu_clock_state_control_monitor mon (
  .clk_sys(clk_sys), .rst(rst), .stop_clock_request_n(stop_clock_request_n),
  .ext_write_buffer_empty_n(ext_write_buffer_empty_n), .ext_addr_strobe_n(ext_addr_strobe_n),
  .address_hold_req(address_hold_req), .bus_clk_running(bus_clk_running),
  .clk_state(clk_state), .special_cycle_valid(special_cycle_valid),
  .pll_running(pll_running), .time_stamp_counter(time_stamp_counter)
);
